// ### hdl/tbc_pkg.sv
// Package for the transmit command A decoder: field layout, codes, types
package tbc_pkg;

  // ************************************************************
  // Command A field positions
  // ************************************************************
  localparam int IOC_BIT      = 31;
  localparam int RSV_HI_MSB   = 30;
  localparam int RSV_HI_LSB   = 26;
  localparam int ALIGN_MSB    = 25;
  localparam int ALIGN_LSB    = 24;
  localparam int OFFSET_MSB   = 20;
  localparam int OFFSET_LSB   = 16;
  localparam int RSV_LO_MSB   = 15;
  localparam int RSV_LO_LSB   = 14;
  localparam int FIRST_BIT    = 13;
  localparam int LAST_BIT     = 12;
  localparam int SIZE_MSB     = 10;
  localparam int SIZE_LSB     = 0;

  // ************************************************************
  // Widths and codes
  // ************************************************************
  localparam int SIZE_W       = 11;
  localparam int OFFSET_W     = 5;
  localparam int POS_W        = 13;
  localparam int WCNT_W       = 11;
  localparam int BYTES_PER_WD = 4;

  localparam logic [1:0] ALIGN_4  = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  localparam logic [1:0] ALIGN_RSV = 2'h3;

  // Round-up masks, in bytes, for each alignment
  localparam logic [POS_W-1:0] RND_4  = 13'h0003;
  localparam logic [POS_W-1:0] RND_16 = 13'h000F;
  localparam logic [POS_W-1:0] RND_32 = 13'h001F;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_CMD_A = 2'b00,
    ST_CMD_B = 2'b01,
    ST_DATA  = 2'b10
  } tbc_state_e;

  typedef struct packed {
    logic                ioc;
    logic [1:0]          align;
    logic [OFFSET_W-1:0] offset;
    logic                first;
    logic                last;
    logic [SIZE_W-1:0]   size;
  } tbc_cmd_a_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] data;
    logic [3:0]  be;
    logic        sop;
    logic        eop;
  } tbc_out_s;

endpackage : tbc_pkg

// ### hdl/tbc_span.sv
// Word counts of one buffer data area from offset, size and end alignment
`timescale 1ns/1ps
`default_nettype none

module tbc_span (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  // Command fields
  input  wire logic                         load,
  input  wire logic [tbc_pkg::OFFSET_W-1:0] offset,
  input  wire logic [tbc_pkg::SIZE_W-1:0]   size,
  input  wire logic [1:0]                   align,
  // Results
  output logic      [tbc_pkg::WCNT_W-1:0]   data_words_q,
  output logic      [tbc_pkg::WCNT_W-1:0]   total_words_q
);

  logic [tbc_pkg::POS_W-1:0] end_pos;
  logic [tbc_pkg::POS_W-1:0] rnd;
  logic [tbc_pkg::POS_W-1:0] data_bytes;
  logic [tbc_pkg::POS_W-1:0] total_bytes;

  assign end_pos = tbc_pkg::POS_W'(offset) + tbc_pkg::POS_W'(size);

  // Reserved code is undefined; it is handled like 4-byte alignment
  always_comb begin
    unique case (align)
      tbc_pkg::ALIGN_16: rnd = tbc_pkg::RND_16;
      tbc_pkg::ALIGN_32: rnd = tbc_pkg::RND_32;
      default:           rnd = tbc_pkg::RND_4;
    endcase
  end

  assign data_bytes  = (end_pos + tbc_pkg::RND_4) & ~tbc_pkg::RND_4;
  assign total_bytes = (end_pos + rnd) & ~rnd;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      data_words_q  <= '0;
      total_words_q <= '0;
    end else if (load) begin
      data_words_q  <= data_bytes[tbc_pkg::POS_W-1:2];
      total_words_q <= total_bytes[tbc_pkg::POS_W-1:2];
    end
  end

endmodule : tbc_span

`default_nettype wire

// ### hdl/tbc_decode.sv
// Transmit buffer command A decoder with offset and padding removal
//
// Functional notes
// - Buffer with completion bit set raises loaded flag after its last word.
// - Loaded flag may drive the host interrupt when the enable input is high.
// - Alignment code: 00 four, 01 sixteen, 10 thirty-two bytes; 11 reserved.
// - Padding words after the payload are dropped, never forwarded.
// - Start offset 0 to 31 bytes; bytes before it are masked off.
// - First-segment bit opens a packet and restarts assembly.
// - Last-segment bit closes the packet and ends assembly.
// - Eleven-bit size is payload byte count; with alignment sets pad words.
// - Sum of buffer sizes differing from packet length sets error flag.
`timescale 1ns/1ps
`default_nettype none

module tbc_decode (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset,
  // Incoming 32-bit words of the transmit data stream
  input  wire logic             in_valid,
  input  wire logic [31:0]      in_data,
  // Payload toward the frame assembler
  output tbc_pkg::tbc_out_s     out_q,
  // Flags and control
  input  wire logic             loaded_clear,
  input  wire logic             error_clear,
  input  wire logic             loaded_irq_en,
  output logic                  tx_buffer_loaded_flag,
  output logic                  transmit_error_flag,
  output logic                  host_irq_q
);

  // ************************************************************
  // Declarations
  // ************************************************************
  tbc_pkg::tbc_state_e            state_q;
  tbc_pkg::tbc_cmd_a_s            cmd_q;
  tbc_pkg::tbc_cmd_a_s            cmd_in;
  logic [31:0]                    cmd_b_q;
  logic [tbc_pkg::SIZE_W-1:0]     plen_q;
  logic [tbc_pkg::POS_W-1:0]      sum_q;
  logic [tbc_pkg::POS_W-1:0]      sum_now;
  logic [tbc_pkg::POS_W-1:0]      plen_now;
  logic                           open_q;
  logic [tbc_pkg::WCNT_W-1:0]     data_words;
  logic [tbc_pkg::WCNT_W-1:0]     total_words;
  logic [tbc_pkg::WCNT_W-1:0]     widx_q;
  logic [tbc_pkg::POS_W-1:0]      pos_q;
  logic [tbc_pkg::POS_W-1:0]      end_pos;
  logic [3:0]                     be;
  logic                           take_a;
  logic                           take_b;
  logic                           take_d;
  logic                           buf_done;
  logic                           is_payload;
  logic                           is_last_pl;
  logic                           cmd_b_err;
  logic                           len_err;

  // ************************************************************
  // Command field extraction
  // ************************************************************
  always_comb begin
    cmd_in.ioc    = in_data[tbc_pkg::IOC_BIT];
    cmd_in.align  = in_data[tbc_pkg::ALIGN_MSB:tbc_pkg::ALIGN_LSB];
    cmd_in.offset = in_data[tbc_pkg::OFFSET_MSB:tbc_pkg::OFFSET_LSB];
    cmd_in.first  = in_data[tbc_pkg::FIRST_BIT];
    cmd_in.last   = in_data[tbc_pkg::LAST_BIT];
    cmd_in.size   = in_data[tbc_pkg::SIZE_MSB:tbc_pkg::SIZE_LSB];
  end

  assign take_a = in_valid && (state_q == tbc_pkg::ST_CMD_A);
  assign take_b = in_valid && (state_q == tbc_pkg::ST_CMD_B);
  assign take_d = in_valid && (state_q == tbc_pkg::ST_DATA);

  // Padding words are counted against the aligned total, not the payload
  tbc_span u_span (
    .core_clk      (core_clk),
    .reset         (reset),
    .load          (take_a),
    .offset        (cmd_in.offset),
    .size          (cmd_in.size),
    .align         (cmd_in.align),
    .data_words_q  (data_words),
    .total_words_q (total_words)
  );

  // Buffer ends on the last aligned word, or at B itself if empty
  assign buf_done = (take_d && (widx_q == total_words - 1'b1)) ||
                    (take_b && (total_words == '0));
  assign is_payload = widx_q < data_words;
  assign is_last_pl = widx_q == data_words - 1'b1;
  assign end_pos    = tbc_pkg::POS_W'(cmd_q.offset) +
                      tbc_pkg::POS_W'(cmd_q.size);

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= tbc_pkg::ST_CMD_A;
    end else begin
      unique case (state_q)
        tbc_pkg::ST_CMD_A: if (take_a) state_q <= tbc_pkg::ST_CMD_B;
        tbc_pkg::ST_CMD_B: if (take_b) begin
          state_q <= buf_done ? tbc_pkg::ST_CMD_A : tbc_pkg::ST_DATA;
        end
        tbc_pkg::ST_DATA:  if (buf_done) state_q <= tbc_pkg::ST_CMD_A;
        default:           state_q <= tbc_pkg::ST_CMD_A;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_q <= '0;
    end else if (take_a) begin
      cmd_q <= cmd_in;
    end
  end

  // Word index and byte position inside the buffer data area
  always_ff @(posedge core_clk) begin
    if (reset) begin
      widx_q <= '0;
      pos_q  <= '0;
    end else if (take_b) begin
      widx_q <= '0;
      pos_q  <= '0;
    end else if (take_d) begin
      widx_q <= widx_q + 1'b1;
      pos_q  <= pos_q + tbc_pkg::POS_W'(tbc_pkg::BYTES_PER_WD);
    end
  end

  // ************************************************************
  // Payload byte enables
  // ************************************************************
  always_comb begin
    for (int i = 0; i < tbc_pkg::BYTES_PER_WD; i++) begin
      be[i] = ((pos_q + tbc_pkg::POS_W'(i)) >=
               tbc_pkg::POS_W'(cmd_q.offset)) &&
              ((pos_q + tbc_pkg::POS_W'(i)) < end_pos);
    end
  end

  // Words before the offset carry no enabled byte and are still dropped
  always_ff @(posedge core_clk) begin
    if (reset) begin
      out_q <= '0;
    end else begin
      out_q.valid <= take_d && is_payload && (be != 4'h0);
      out_q.data  <= in_data;
      out_q.be    <= be;
      out_q.sop   <= cmd_q.first &&
                     (pos_q <= tbc_pkg::POS_W'(cmd_q.offset)) &&
                     (pos_q + tbc_pkg::POS_W'(tbc_pkg::BYTES_PER_WD) >
                      tbc_pkg::POS_W'(cmd_q.offset));
      out_q.eop   <= cmd_q.last && is_last_pl;
    end
  end

  // ************************************************************
  // Packet length accounting
  // ************************************************************
  assign sum_now = (cmd_q.first ? '0 : sum_q) +
                   tbc_pkg::POS_W'(cmd_q.size);

  // Command B must repeat within a packet; a middle buffer needs one open
  assign cmd_b_err = take_b && !cmd_q.first &&
                     (!open_q || (in_data != cmd_b_q));
  // An empty buffer ends at B, before the sum and length registers load
  assign plen_now  = (take_b && cmd_q.first) ? tbc_pkg::POS_W'(cmd_in.size) :
                                               tbc_pkg::POS_W'(plen_q);
  assign len_err   = buf_done && cmd_q.last &&
                     ((take_b ? sum_now : sum_q) != plen_now);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      cmd_b_q <= '0;
      plen_q  <= '0;
      sum_q   <= '0;
      open_q  <= 1'b0;
    end else begin
      if (take_b) begin
        sum_q <= sum_now;
        if (cmd_q.first) begin
          cmd_b_q <= in_data;
          plen_q  <= in_data[tbc_pkg::SIZE_MSB:tbc_pkg::SIZE_LSB];
          open_q  <= 1'b1;
        end
      end
      if (buf_done && cmd_q.last) begin
        open_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Sticky flags; a set in the clear cycle wins
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tx_buffer_loaded_flag <= 1'b0;
    end else if (buf_done && cmd_q.ioc) begin
      tx_buffer_loaded_flag <= 1'b1;
    end else if (loaded_clear) begin
      tx_buffer_loaded_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      transmit_error_flag <= 1'b0;
    end else if (cmd_b_err || len_err) begin
      transmit_error_flag <= 1'b1;
    end else if (error_clear) begin
      transmit_error_flag <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      host_irq_q <= 1'b0;
    end else begin
      // Follows the flag's next value so a clear drops it at once
      host_irq_q <= loaded_irq_en &&
                    ((buf_done && cmd_q.ioc) ||
                     (tx_buffer_loaded_flag && !loaded_clear));
    end
  end

endmodule : tbc_decode

`default_nettype wire

// ### sim/tbc_properties.sv
// Concurrent checks on the ports of the transmit command A decoder
`timescale 1ns/1ps
`default_nettype none

module tbc_properties (
  // Clock and reset
  input wire logic              core_clk,
  input wire logic              reset,
  // Word stream and payload
  input wire logic              in_valid,
  input wire logic [31:0]       in_data,
  input wire tbc_pkg::tbc_out_s out_q,
  // Flags and control
  input wire logic              loaded_clear,
  input wire logic              error_clear,
  input wire logic              loaded_irq_en,
  input wire logic              tx_buffer_loaded_flag,
  input wire logic              transmit_error_flag,
  input wire logic              host_irq_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_fwd;
    out_q.valid;
  endsequence
  sequence s_en_held;
    loaded_irq_en [*2] ##0 tx_buffer_loaded_flag;
  endsequence

  fwd_latency_a: assert property (s_fwd |-> $past(in_valid))
    else $error("payload word without a word taken one cycle before");
  pad_drop_a: assert property (s_fwd |-> out_q.be != 4'h0)
    else $error("payload word forwarded with no byte enabled");
  loaded_hold_a: assert property (
    tx_buffer_loaded_flag && !loaded_clear |=> tx_buffer_loaded_flag)
    else $error("loaded flag dropped without a clear");
  loaded_set_a: assert property (
    $rose(tx_buffer_loaded_flag) |-> $past(in_valid))
    else $error("loaded flag rose without a taken word");
  loaded_clear_a: assert property (
    loaded_clear && !in_valid |=> !tx_buffer_loaded_flag)
    else $error("loaded flag survived a clear");
  error_hold_a: assert property (
    transmit_error_flag && !error_clear |=> transmit_error_flag)
    else $error("error flag dropped without a clear");
  error_clear_a: assert property (
    error_clear && !in_valid |=> !transmit_error_flag)
    else $error("error flag survived a clear");
  irq_off_a: assert property (!tx_buffer_loaded_flag |-> !host_irq_q)
    else $error("host interrupt without loaded flag");
  irq_on_a: assert property (s_en_held |-> host_irq_q)
    else $error("host interrupt missing while routed");
endmodule : tbc_properties

bind tbc_decode tbc_properties i_props (.core_clk(core_clk), .reset(reset),
  .in_valid(in_valid), .in_data(in_data), .out_q(out_q),
  .loaded_clear(loaded_clear), .error_clear(error_clear),
  .loaded_irq_en(loaded_irq_en),
  .tx_buffer_loaded_flag(tx_buffer_loaded_flag),
  .transmit_error_flag(transmit_error_flag), .host_irq_q(host_irq_q));

`default_nettype wire

// ### sim/tbc_host.sv
// Host model writing command words and padded buffers into the decoder
`timescale 1ns/1ps
`default_nettype none

module tbc_host (
  // Clock
  input  wire logic        core_clk,
  // Word stream toward the decoder
  output var  logic        in_valid,
  output var  logic [31:0] in_data
);
  initial begin
    in_valid = 1'b0;
    in_data  = 32'h0;
  end

  task put(input logic [31:0] w);
    @(posedge core_clk);
    in_valid <= 1'b1;
    in_data  <= w;
  endtask : put

  // Gap idles before each data word to model a slow host
  task send(input logic [31:0] a, input logic [31:0] b,
            input logic [31:0] base, input int gap);
    int rnd;
    int n;
    rnd = (a[25:24] == 2'h1) ? 16 : (a[25:24] == 2'h2) ? 32 : 4;
    n = (int'(a[20:16]) + int'(a[10:0]) + rnd - 1) / rnd * rnd / 4;
    put(a & 32'h83FF_37FF);
    put(b);
    for (int k = 0; k < n; k++) begin
      repeat (gap) begin
        @(posedge core_clk);
        in_valid <= 1'b0;
        in_data  <= ~in_data;
      end
      put(base + 32'(k));
    end
    @(posedge core_clk);
    in_valid <= 1'b0;
    // Released bus shows no stale word
    in_data  <= ~in_data;
  endtask : send
endmodule : tbc_host

`default_nettype wire

// ### sim/tx_buffer_command_a_decode_bench.sv
// Self-checking bench for the transmit command A decoder
`timescale 1ns/1ps
`default_nettype none

module tx_buffer_command_a_decode_bench;
  logic              core_clk;
  logic              reset;
  logic              in_valid;
  logic [31:0]       in_data;
  tbc_pkg::tbc_out_s out_q;
  logic              loaded_clear;
  logic              error_clear;
  logic              loaded_irq_en;
  logic              tx_buffer_loaded_flag;
  logic              transmit_error_flag;
  logic              host_irq_q;
  int                n_errors = 0;
  int                num_checks = 0;
  int                cyc = 0;
  tbc_pkg::tbc_out_s got_q[$];

  tbc_host i_host (.core_clk(core_clk), .in_valid(in_valid),
    .in_data(in_data));
  tbc_decode i_dut (.core_clk(core_clk), .reset(reset),
    .in_valid(in_valid), .in_data(in_data), .out_q(out_q),
    .loaded_clear(loaded_clear), .error_clear(error_clear),
    .loaded_irq_en(loaded_irq_en),
    .tx_buffer_loaded_flag(tx_buffer_loaded_flag),
    .transmit_error_flag(transmit_error_flag), .host_irq_q(host_irq_q));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Collect forwarded words; bound the run against a hang
  always @(posedge core_clk) begin
    if (out_q.valid === 1'b1) got_q.push_back(out_q);
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      print_verdict();
    end
  end

  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  task chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : chk_bit

  task chk_out(input tbc_pkg::tbc_out_s exp);
    tbc_pkg::tbc_out_s got;
    num_checks++;
    got = (got_q.size() > 0) ? got_q.pop_front() : '0;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: payload word %h", $time, got);
    end
  endtask : chk_out

  // Expected payload words follow from offset, size and segment bits
  task run_buf(input logic [31:0] a, input logic [31:0] b,
               input logic [31:0] base, input int gap);
    int off;
    int sz;
    tbc_pkg::tbc_out_s e;
    got_q.delete();
    i_host.send(a, b, base, gap);
    repeat (3) @(posedge core_clk);
    off = int'(a[20:16]);
    sz  = int'(a[10:0]);
    for (int w = off / 4; w * 4 < off + sz; w++) begin
      e = '0;
      e.valid = 1'b1;
      e.data = base + 32'(w);
      for (int l = 0; l < 4; l++) e.be[l] = (w*4+l >= off) && (w*4+l < off+sz);
      e.sop = a[13] && (w == off / 4);
      e.eop = a[12] && ((w + 1) * 4 >= off + sz);
      chk_out(e);
    end
    chk_bit(got_q.size() == 0, 1'b1, "words beyond payload forwarded");
  endtask : run_buf

  task pulse(input logic err);
    @(posedge core_clk);
    loaded_clear <= !err;
    error_clear  <= err;
    @(posedge core_clk);
    loaded_clear <= 1'b0;
    error_clear  <= 1'b0;
    @(posedge core_clk);
  endtask : pulse

  initial begin
    reset = 1'b1;
    loaded_clear = 1'b0;
    error_clear = 1'b0;
    loaded_irq_en = 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    run_buf(32'h8102_3005, 32'h0000_0005, 32'h1111_0000, 0);
    chk_bit(tx_buffer_loaded_flag, 1'b1, "loaded flag not set");
    chk_bit(host_irq_q, 1'b1, "interrupt not routed");
    pulse(1'b0);
    chk_bit(tx_buffer_loaded_flag, 1'b0, "loaded flag not cleared");
    chk_bit(host_irq_q, 1'b0, "interrupt stuck");
    $display("test done: completion flag");
    run_buf(32'h021F_3001, 32'h0000_0001, 32'h2222_0000, 2);
    chk_bit(tx_buffer_loaded_flag, 1'b0, "loaded flag without request");
    $display("test done: largest offset");
    run_buf(32'h0000_2008, 32'h0000_000F, 32'h3333_0000, 0);
    run_buf(32'h0101_0004, 32'h0000_000F, 32'h4444_0000, 1);
    run_buf(32'h0203_1003, 32'h0000_000F, 32'h5555_0000, 0);
    chk_bit(transmit_error_flag, 1'b0, "error on matching length");
    $display("test done: three segments");
    loaded_irq_en <= 1'b0;
    run_buf(32'h8000_3004, 32'h0000_0006, 32'h6666_0000, 0);
    chk_bit(transmit_error_flag, 1'b1, "length mismatch missed");
    chk_bit(tx_buffer_loaded_flag, 1'b1, "loaded flag not set");
    chk_bit(host_irq_q, 1'b0, "interrupt not masked");
    pulse(1'b1);
    chk_bit(transmit_error_flag, 1'b0, "error flag not cleared");
    chk_bit(tx_buffer_loaded_flag, 1'b1, "loaded flag lost");
    $display("test done: length mismatch");
    run_buf(32'h0000_0004, 32'h0000_0004, 32'h7777_0000, 0);
    chk_bit(transmit_error_flag, 1'b1, "stray command B missed");
    $display("test done: stray middle buffer");
    print_verdict();
  end
endmodule : tx_buffer_command_a_decode_bench

`default_nettype wire
